/* logic/hb_fault_pkg.sv */
// constants and carrier types for the half-bridge fault supervisor
package hb_fault_pkg;

  localparam int CLK_FREQ_MHZ = 200;
  localparam int NUM_HALF_BRIDGES = 12;
  localparam int UNDERLOAD_DELAY_US = 200;
  localparam int CLEAR_HOLDOFF_US = 100;
  localparam int SYNC_STAGES = 2;
  localparam int STATUS_WIDTH = 16;
  localparam int STATUS_TSD_POS = 15;
  localparam int STATUS_UL_POS = 13;
  localparam int STATUS_WARN_POS = 0;
  localparam int STATUS_OFF_LSB = 1;
  localparam int UNDERLOAD_DELAY_CYCLES = UNDERLOAD_DELAY_US * CLK_FREQ_MHZ;
  localparam int CLEAR_HOLDOFF_CYCLES = CLEAR_HOLDOFF_US * CLK_FREQ_MHZ;
  localparam int GROUP_SIZE = NUM_HALF_BRIDGES / 2;

  typedef enum logic {
    UL_IDLE,
    UL_RUN
  } ul_state_type;

  typedef struct packed {
    logic thermalShutdownFlag;
    logic thermalWarningFlag;
    logic underloadFlag;
    logic [GROUP_SIZE-1:0] groupOff;
  } status_type;

  localparam status_type STATUS_RESET = '0;

endpackage : hb_fault_pkg

/* logic/half_bridge_fault_protect.sv */
// fault supervision: underload timer, thermal latches, reset requests, early shutdown readout
`timescale 1ns/1ps
module half_bridge_fault_protect #(
  parameter int NUM_HB = hb_fault_pkg::NUM_HALF_BRIDGES,
  parameter int UL_DELAY_CYC = hb_fault_pkg::UNDERLOAD_DELAY_CYCLES,
  parameter int HOLDOFF_CYC = hb_fault_pkg::CLEAR_HOLDOFF_CYCLES
) (
  input logic clk_sys,
  input logic srst,
  input logic serialClk,
  input logic chipSelectN,
  input logic enablePin,
  input logic [NUM_HB-1:0] underloadRaw,
  input logic [NUM_HB-1:0] warnRaw,
  input logic [NUM_HB-1:0] shutRaw,
  input logic [NUM_HB-1:0] highSideCmd,
  input logic [NUM_HB-1:0] lowSideCmd,
  input logic underloadShutdownEnable,
  input logic channelGroupSelect,
  input logic statusResetRequest,
  input logic shiftDataOut,
  output logic [NUM_HB-1:0] highSideDriver,
  output logic [NUM_HB-1:0] lowSideDriver,
  output logic [NUM_HB-1:0] latchedOff,
  output logic [NUM_HB-1:0] underloadFlagVec,
  output logic serialOut,
  output hb_fault_pkg::status_type status,
  output logic [hb_fault_pkg::STATUS_WIDTH-1:0] statusWord,
  output logic clearHoldoffBusy
);

  localparam int HALF = NUM_HB / 2;
  localparam int SYNC_W = 3 * NUM_HB + 5;
  // select idles high; a zero here would fake a frame end after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(5'h10);
  localparam int UL_W = $clog2(UL_DELAY_CYC + 1);
  localparam int HO_W = $clog2(HOLDOFF_CYC + 1);
  localparam logic [UL_W-1:0] UL_LAST = UL_W'(UL_DELAY_CYC - 1);
  localparam logic [UL_W-1:0] UL_ZERO = '0;
  localparam logic [UL_W-1:0] UL_ONE = UL_W'(1);
  localparam logic [HO_W-1:0] HO_LOAD = HO_W'(HOLDOFF_CYC);
  localparam logic [HO_W-1:0] HO_ZERO = '0;
  localparam logic [HO_W-1:0] HO_ONE = HO_W'(1);

  // lower half when select is 0, upper half when 1
  function automatic logic [NUM_HB-1:0] groupMask(input logic sel);
    logic [NUM_HB-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_HB; i++) begin
      m[i] = sel ? (i >= HALF) : (i < HALF);
    end
    return m;
  endfunction : groupMask

  function automatic logic [HALF-1:0] groupPick(input logic [NUM_HB-1:0] v,
                                                input logic sel);
    return sel ? v[NUM_HB-1:HALF] : v[HALF-1:0];
  endfunction : groupPick

  // synchroniser for every pin-level input except the drive commands, the serial clock and the serial data
  logic [SYNC_W-1:0] syncMeta_ff;
  logic [SYNC_W-1:0] syncOut_ff;
  wire [SYNC_W-1:0] syncIn = {underloadRaw, warnRaw, shutRaw, chipSelectN, enablePin,
                              underloadShutdownEnable, channelGroupSelect,
                              statusResetRequest};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      syncMeta_ff <= SYNC_IDLE;
      syncOut_ff <= SYNC_IDLE;
    end else begin
      syncMeta_ff <= syncIn;
      syncOut_ff <= syncMeta_ff;
    end
  end

  wire [NUM_HB-1:0] ulSync = syncOut_ff[SYNC_W-1 -: NUM_HB];
  wire [NUM_HB-1:0] warnSync = syncOut_ff[2*NUM_HB+4 -: NUM_HB];
  wire [NUM_HB-1:0] shutSync = syncOut_ff[NUM_HB+4 -: NUM_HB];
  wire selSync = syncOut_ff[4];
  wire enSync = syncOut_ff[3];
  wire ulsdSync = syncOut_ff[2];
  wire grpSync = syncOut_ff[1];
  wire clrReqSync = syncOut_ff[0];

  // frame boundary and reset request
  logic selPrev_ff;
  logic [HO_W-1:0] holdoff_ff;
  logic [HO_W-1:0] nxt_holdoff;
  logic clrFrame_ff;

  wire selRise = selSync & ~selPrev_ff;
  wire holdoffRun = (holdoff_ff != HO_ZERO);
  // a request inside holdoff is dropped silently, not queued
  wire clrApply = selRise & clrReqSync & ~holdoffRun;
  wire [NUM_HB-1:0] grpMask = groupMask(grpSync);
  wire [NUM_HB-1:0] clrGroup = clrApply ? grpMask : '0;
  wire enableLow = ~enSync;

  assign nxt_holdoff = clrApply ? HO_LOAD :
                       holdoffRun ? holdoff_ff - HO_ONE : holdoff_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      selPrev_ff <= 1'b1;
      holdoff_ff <= HO_ZERO;
    end else begin
      selPrev_ff <= selSync;
      holdoff_ff <= nxt_holdoff;
    end
  end

  // shared underload delay timer
  hb_fault_pkg::ul_state_type ulState_ff;
  hb_fault_pkg::ul_state_type nxt_ulState;
  logic [UL_W-1:0] ulCnt_ff;
  logic [UL_W-1:0] nxt_ulCnt;
  logic ulExpire;

  wire anyUl = |ulSync;

  always_comb begin
    nxt_ulState = ulState_ff;
    nxt_ulCnt = ulCnt_ff;
    ulExpire = 1'b0;
    case (ulState_ff)
      hb_fault_pkg::UL_IDLE: begin
        if (anyUl) begin
          nxt_ulState = hb_fault_pkg::UL_RUN;
          nxt_ulCnt = UL_ZERO;
        end
      end
      hb_fault_pkg::UL_RUN: begin
        if (!anyUl) begin
          nxt_ulState = hb_fault_pkg::UL_IDLE;
          nxt_ulCnt = UL_ZERO;
        end else if (ulCnt_ff == UL_LAST) begin
          ulExpire = 1'b1;
          nxt_ulCnt = UL_ZERO;
        end else begin
          nxt_ulCnt = ulCnt_ff + UL_ONE;
        end
      end
      default: begin
        nxt_ulState = hb_fault_pkg::UL_IDLE;
        nxt_ulCnt = UL_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ulState_ff <= hb_fault_pkg::UL_IDLE;
      ulCnt_ff <= UL_ZERO;
    end else begin
      ulState_ff <= nxt_ulState;
      ulCnt_ff <= nxt_ulCnt;
    end
  end

  // channels that joined mid-run are judged at this same expiry
  wire [NUM_HB-1:0] ulQualify = ulExpire ? ulSync : '0;
  wire [NUM_HB-1:0] ulLatchSet = ulQualify & grpMask & {NUM_HB{ulsdSync}};

  // per-channel latches; set wins over a clear in the same cycle
  logic [NUM_HB-1:0] ulFlag_ff;
  logic [NUM_HB-1:0] ulOff_ff;
  logic [NUM_HB-1:0] tsdOff_ff;
  logic [NUM_HB-1:0] hiDrv_ff;
  logic [NUM_HB-1:0] loDrv_ff;

  wire [NUM_HB-1:0] clrAll = enableLow ? '1 : clrGroup;
  wire [NUM_HB-1:0] nxt_ulFlag = ulQualify | (ulFlag_ff & ~clrAll);
  wire [NUM_HB-1:0] nxt_ulOff = ulLatchSet | (ulOff_ff & ~clrAll);
  // a still-hot channel re-latches at once, so only cooled ones reactivate
  wire [NUM_HB-1:0] nxt_tsdOff = shutSync | (tsdOff_ff & ~clrAll);
  wire [NUM_HB-1:0] offNow = ulOff_ff | tsdOff_ff;
  // warning is deliberately absent from the gate
  wire [NUM_HB-1:0] allowOn = ~offNow & {NUM_HB{enSync}};

  genvar g;
  generate
    for (g = 0; g < NUM_HB; g++) begin : g_hb
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          ulFlag_ff[g] <= 1'b0;
          ulOff_ff[g] <= 1'b0;
          tsdOff_ff[g] <= 1'b0;
          hiDrv_ff[g] <= 1'b0;
          loDrv_ff[g] <= 1'b0;
        end else begin
          ulFlag_ff[g] <= nxt_ulFlag[g];
          ulOff_ff[g] <= nxt_ulOff[g];
          tsdOff_ff[g] <= nxt_tsdOff[g];
          hiDrv_ff[g] <= highSideCmd[g] & allowOn[g];
          loDrv_ff[g] <= lowSideCmd[g] & allowOn[g];
        end
      end
    end
  endgenerate

  assign highSideDriver = hiDrv_ff;
  assign lowSideDriver = loDrv_ff;
  assign latchedOff = offNow;
  assign underloadFlagVec = ulFlag_ff;

  // status snapshot
  hb_fault_pkg::status_type status_ff;
  hb_fault_pkg::status_type liveStatus;

  always_comb begin
    liveStatus = hb_fault_pkg::STATUS_RESET;
    liveStatus.thermalShutdownFlag = |tsdOff_ff;
    liveStatus.thermalWarningFlag = |warnSync;
    liveStatus.underloadFlag = |(ulFlag_ff & grpMask);
    liveStatus.groupOff = groupPick(offNow, grpSync);
  end

  // after a reset frame the old snapshot is kept until the next frame ends
  wire snapUpdate = selSync & ~clrFrame_ff & ~clrApply;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_ff <= hb_fault_pkg::STATUS_RESET;
      clrFrame_ff <= 1'b0;
    end else begin
      if (snapUpdate) begin
        status_ff <= liveStatus;
      end
      if (clrApply) begin
        clrFrame_ff <= 1'b1;
      end else if (selRise) begin
        clrFrame_ff <= 1'b0;
      end
    end
  end

  assign status = status_ff;
  assign clearHoldoffBusy = holdoffRun;

  always_comb begin
    statusWord = '0;
    statusWord[hb_fault_pkg::STATUS_TSD_POS] = status_ff.thermalShutdownFlag;
    statusWord[hb_fault_pkg::STATUS_UL_POS] = status_ff.underloadFlag;
    statusWord[hb_fault_pkg::STATUS_WARN_POS] = status_ff.thermalWarningFlag;
    statusWord[hb_fault_pkg::STATUS_OFF_LSB +: HALF] = status_ff.groupOff;
  end

  // link side: marks the first serial clock rise of the frame
  logic clkSeen_ff;

  // select high clears it; the serial clock may stand still between frames
  always_ff @(posedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      clkSeen_ff <= 1'b0;
    end else begin
      clkSeen_ff <= 1'b1;
    end
  end

  // snapshot is frozen while the synchronised select is low, so the early bit is stable from two clocks after select falls
  wire earlyWindow = ~chipSelectN & ~clkSeen_ff;
  assign serialOut = earlyWindow ? status_ff.thermalShutdownFlag : shiftDataOut;

endmodule : half_bridge_fault_protect

/* sim/hb_fault_properties.sv */
// concurrent checks on the fault supervisor ports
`timescale 1ns/1ps
module hb_fault_properties #(
  parameter int NUM_HB = 12,
  parameter int UL_DELAY_CYC = 16,
  parameter int HOLDOFF_CYC = 200
) (
  input logic clk_sys,
  input logic srst,
  input logic chipSelectN,
  input logic enablePin,
  input logic [NUM_HB-1:0] underloadRaw,
  input logic [NUM_HB-1:0] shutRaw,
  input logic [NUM_HB-1:0] highSideCmd,
  input logic [NUM_HB-1:0] highSideDriver,
  input logic [NUM_HB-1:0] latchedOff,
  input logic [NUM_HB-1:0] underloadFlagVec,
  input logic serialOut,
  input hb_fault_pkg::status_type status,
  input logic clearHoldoffBusy
);
  // margin covers synchroniser and flag register latency
  localparam int ULW = UL_DELAY_CYC + 8;
  localparam int HM1 = HOLDOFF_CYC - 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence ulStart;
    $rose(|underloadRaw) && underloadFlagVec == '0;
  endsequence
  AST_UL_QUIET:
    assert property (ulStart |-> ((underloadFlagVec == '0) throughout (##UL_DELAY_CYC 1'b1)))
    else $error("underload flag before delay");
  AST_UL_DEADLINE:
    assert property (ulStart |-> ##[UL_DELAY_CYC:ULW] (|underloadFlagVec))
    else $error("underload flag late");
  AST_TSD_LATCH:
    assert property ($rose(|shutRaw) |-> ##[2:4] (|latchedOff))
    else $error("shutdown not latched");
  AST_DRV_OFF:
    assert property ((highSideDriver & $past(latchedOff)) == '0)
    else $error("driver on while latched off");
  AST_DRV_CMD:
    assert property ((highSideDriver & ~$past(highSideCmd)) == '0)
    else $error("driver on without command");
  AST_ENABLE_CLEAR:
    assert property (!enablePin [*4] |-> highSideDriver == '0 && latchedOff == '0)
    else $error("enable low did not clear");
  AST_EARLY_TSD:
    assert property ($fell(chipSelectN) |-> ##1 serialOut == status.thermalShutdownFlag)
    else $error("early shutdown bit wrong");
  AST_HOLDOFF:
    assert property ($rose(clearHoldoffBusy) |-> ##HM1 clearHoldoffBusy ##1 !clearHoldoffBusy)
    else $error("holdoff length wrong");
  COV_CLEAR: cover property ($rose(clearHoldoffBusy));
  COV_UL: cover property ($rose(|underloadFlagVec));
  COV_OFF: cover property ($rose(|latchedOff));
endmodule : hb_fault_properties
bind half_bridge_fault_protect hb_fault_properties #(.NUM_HB(NUM_HB),
  .UL_DELAY_CYC(UL_DELAY_CYC), .HOLDOFF_CYC(HOLDOFF_CYC)) chk (.*);

/* sim/spi_host_model.sv */
// host serial master: frames, command bits, early shutdown sample
`timescale 1ns/1ps
module spi_host_model (
  output logic serialClk,
  output logic chipSelectN,
  output logic shiftDataOut,
  output logic underloadShutdownEnable,
  output logic channelGroupSelect,
  output logic statusResetRequest,
  input logic serialOut
);
  initial begin
    serialClk = 1'h0;
    chipSelectN = 1'h1;
    shiftDataOut = 1'h0;
    underloadShutdownEnable = 1'h0;
    channelGroupSelect = 1'h0;
    statusResetRequest = 1'h0;
  end
  // group and underload bits stay as sent between frames; the reset request drops to 0 after each
  task automatic frame(input logic clr, input logic grp, input logic uls, output logic tsd);
    #3 channelGroupSelect = grp;
    underloadShutdownEnable = uls;
    statusResetRequest = clr;
    chipSelectN = 1'h0;
    #40 tsd = serialOut;
    repeat (16) begin
      #16 serialClk = 1'h1;
      #16 serialClk = 1'h0;
      shiftDataOut = ~shiftDataOut;
    end
    #20 chipSelectN = 1'h1;
    #60 statusResetRequest = 1'h0;
  endtask : frame
endmodule : spi_host_model

/* sim/tb_top.sv */
// self-checking bench for the half-bridge fault supervisor
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic enablePin = 1'h0;
  logic [11:0] underloadRaw = '0, warnRaw = '0, shutRaw = '0;
  logic [11:0] highSideCmd = 12'hFFF, lowSideCmd = 12'hFFF;
  logic serialClk, chipSelectN, shiftDataOut, serialOut, clearHoldoffBusy, t;
  logic underloadShutdownEnable, channelGroupSelect, statusResetRequest;
  logic [11:0] highSideDriver, lowSideDriver, latchedOff, underloadFlagVec;
  hb_fault_pkg::status_type status;
  logic [15:0] statusWord;
  int errors = 0;
  int checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  half_bridge_fault_protect #(.UL_DELAY_CYC(16), .HOLDOFF_CYC(200)) dut (.*);
  spi_host_model host (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic frm(input logic clr, input logic grp, input logic uls);
    host.frame(clr, grp, uls, t);
    cyc(2);
  endtask : frm
  task automatic waitIdle();
    for (int i = 0; i < 400 && clearHoldoffBusy !== 1'h0; i++) @(negedge clk_sys);
    chk(16'(clearHoldoffBusy), 16'h0000, "holdoff end");
  endtask : waitIdle
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // full run is near 8 us; over twelve times that means a hang
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial begin
    cyc(16);
    srst = 1'h0;
    enablePin = 1'h1;
    cyc(4);
    chk(statusWord, 16'h0000, "reset status");
    warnRaw = 12'h008;
    cyc(5);
    chk(16'(statusWord[0]), 16'h0001, "warn set");
    chk(16'(highSideDriver), 16'h0FFF, "warn drivers");
    warnRaw = '0;
    cyc(5);
    chk(16'(statusWord[0]), 16'h0000, "warn clear");
    shutRaw = 12'h004;
    cyc(5);
    chk(16'(statusWord[15]), 16'h0001, "tsd bit");
    chk(16'(highSideDriver), 16'h0FFB, "tsd drivers");
    frm(1'h0, 1'h0, 1'h0);
    chk(16'(t), 16'h0001, "early tsd");
    shutRaw = '0;
    cyc(4);
    frm(1'h1, 1'h0, 1'h0);
    chk(16'(latchedOff), 16'h0000, "tsd release");
    chk(16'(statusWord[15]), 16'h0001, "snapshot held");
    $display("thermal test done");
    waitIdle();
    frm(1'h0, 1'h1, 1'h1);
    chk(16'(statusWord[15]), 16'h0000, "snapshot updated");
    underloadRaw = 12'h082;
    cyc(8);
    underloadRaw = 12'h182;
    cyc(2);
    chk(16'(underloadFlagVec), 16'h0000, "ul delay");
    cyc(16);
    chk(16'(underloadFlagVec), 16'h0182, "ul remainder");
    chk(16'(latchedOff), 16'h0180, "ul group latch");
    chk(16'(lowSideDriver), 16'h0E7F, "ul drivers");
    underloadRaw = 12'h582;
    cyc(14);
    chk(16'(latchedOff), 16'h0580, "ul timer runs");
    underloadRaw = '0;
    cyc(4);
    frm(1'h1, 1'h1, 1'h1);
    chk(16'(underloadFlagVec), 16'h0002, "ul group clear");
    chk(16'(latchedOff), 16'h0000, "ul reactivate");
    $display("underload test done");
    waitIdle();
    frm(1'h0, 1'h1, 1'h0);
    underloadRaw = 12'h200;
    cyc(30);
    chk(16'(underloadFlagVec), 16'h0202, "ul flag only");
    chk(16'(latchedOff), 16'h0000, "ul no latch");
    underloadRaw = '0;
    frm(1'h1, 1'h0, 1'h0);
    chk(16'(underloadFlagVec), 16'h0200, "group0 clear");
    chk(16'(clearHoldoffBusy), 16'h0001, "holdoff busy");
    frm(1'h1, 1'h1, 1'h0);
    chk(16'(underloadFlagVec), 16'h0200, "request refused");
    waitIdle();
    frm(1'h1, 1'h1, 1'h0);
    chk(16'(underloadFlagVec), 16'h0000, "request after holdoff");
    $display("reset request test done");
    underloadRaw = 12'h001;
    cyc(30);
    underloadRaw = '0;
    enablePin = 1'h0;
    cyc(4);
    enablePin = 1'h1;
    cyc(4);
    chk(16'(underloadFlagVec), 16'h0000, "enable clear");
    $display("enable test done");
    tally_and_finish();
  end
endmodule : tb_top
